// File: verilog/stpcr_regs.sv
`timescale 1ns/100ps
`include "stpcr_consts.svh"

// Notes on behaviour
// - Bridge outputs are disabled while motor enable is 0, enabled while 1.
// - Direction pin equal to invert bit gives clockwise, differing gives counter-clockwise.
// - Step advances on rising step edge when polarity is 0, falling when 1.
// - Five-bit current code maps through fixed table, 15 mA up to 800 mA.
// - Slew code 00,01,10,11 gives 150,100,50,25 V per microsecond.
// - Mode code selects 1/32..1/4, half uncompensated, half compensated, full, reserved.
// - Four read-only status registers clear to zero on reset.
// - Fault register: parity bit 7, thermal warning 6, pump failure 5, live.
// - Fault register: open coil X bit 3, Y bit 2; bits 4,1,0 zero.
// - X over-current register holds four bridge flags in bits 6 to 3.
// - X over-current flags are latched beyond the end of the event.
// - Y register holds four bridge over-current flags in bits 6 to 3.
// - Y register holds latched thermal shutdown in bit 2.
// - Position register shows live micro-step position low seven bits, parity bit 7.
// - Status snapshot refreshes only while serial chip select is high.
module stpcr_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire stpcr_pkg::stpcr_wr_t wr,
  input  wire logic                 rd_load,
  input  wire logic [2:0]           rd_addr,
  output logic [7:0]                rd_data,
  input  wire logic                 serial_chip_select,
  input  wire logic                 direction_pin,
  input  wire logic                 step_input_pin,
  input  wire stpcr_pkg::stpcr_cond_t cond,
  input  wire logic [6:0]           microstep_position,
  output logic                      bridge_enable,
  output logic                      dir_ccw,
  output logic                      step_pulse,
  output logic [9:0]                coil_current_ma,
  output logic [7:0]                slope_v_per_us,
  output stpcr_pkg::stpcr_mode_t    step_mode
);
  import stpcr_pkg::*;

  localparam logic [9:0] CUR_LUT [32] = '{
    10'h00F, 10'h01E, 10'h02D, 10'h032, 10'h037, 10'h03D, 10'h043, 10'h04A,
    10'h052, 10'h05B, 10'h064, 10'h06E, 10'h07A, 10'h087, 10'h095, 10'h0A4,
    10'h0B5, 10'h0C8, 10'h0DD, 10'h0F4, 10'h10D, 10'h129, 10'h148, 10'h16A,
    10'h190, 10'h1B9, 10'h1E7, 10'h21A, 10'h252, 10'h290, 10'h2D4, 10'h320
  };
  localparam logic [7:0] SLOPE_LUT [4] = '{8'h96, 8'h64, 8'h32, 8'h19};
  localparam int SYNC_W = $bits(stpcr_cond_t) + 3;

  function automatic logic [7:0] with_par(input logic [6:0] d);
    with_par = {(^d) ^ `STPCR_PAR_ODD, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one feeds stage two only
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic              step_d_r;
  stpcr_cond_t       cond_s;
  logic              cs_s, dir_s, step_s;

  assign {cond_s, cs_s, dir_s, step_s} = sync2_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      step_d_r <= 1'b0;
    end else begin
      sync1_r  <= {cond, serial_chip_select, direction_pin, step_input_pin};
      sync2_r  <= sync1_r;
      step_d_r <= step_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] cr0_r, cr1_r, cr2_r, cr0_nxt, cr1_nxt, cr2_nxt;

  always_comb begin
    cr0_nxt = cr0_r;
    cr1_nxt = cr1_r;
    cr2_nxt = cr2_r;
    if (wr.en) begin
      case (wr.addr)
        `STPCR_OFF_CR0: cr0_nxt = wr.data;
        `STPCR_OFF_CR1: cr1_nxt = wr.data;
        `STPCR_OFF_CR2: cr2_nxt = wr.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cr0_r <= `STPCR_CTRL_RST;
      cr1_r <= `STPCR_CTRL_RST;
      cr2_r <= `STPCR_CTRL_RST;
    end else begin
      cr0_r <= cr0_nxt;
      cr1_r <= cr1_nxt;
      cr2_r <= cr2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded control outputs
  logic [4:0]  peak_current_code;
  logic [1:0]  slew_rate_code;
  logic [2:0]  step_mode_code;
  logic        step_pol;
  logic        bridge_en_nxt, dir_ccw_nxt, step_pulse_nxt;
  logic [9:0]  cur_nxt;
  logic [7:0]  slope_nxt;
  stpcr_mode_t mode_nxt;

  assign peak_current_code = cr0_r[`STPCR_CUR_MSB:`STPCR_CUR_LSB];
  assign step_mode_code    = cr0_r[`STPCR_MODE_MSB:`STPCR_MODE_LSB];
  assign slew_rate_code    = cr1_r[`STPCR_SLEW_MSB:`STPCR_SLEW_LSB];
  assign step_pol          = cr1_r[`STPCR_STEPPOL_BIT];

  always_comb begin
    bridge_en_nxt  = cr2_r[`STPCR_MOTEN_BIT];
    dir_ccw_nxt    = dir_s ^ cr1_r[`STPCR_DIRINV_BIT];
    step_pulse_nxt = step_pol ? (step_d_r & ~step_s)
                              : (step_s & ~step_d_r);
    cur_nxt        = CUR_LUT[peak_current_code];
    slope_nxt      = SLOPE_LUT[slew_rate_code];
    mode_nxt       = stpcr_mode_t'(step_mode_code);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bridge_enable   <= 1'b0;
      dir_ccw         <= 1'b0;
      step_pulse      <= 1'b0;
      coil_current_ma <= 10'h000;
      slope_v_per_us  <= 8'h00;
      step_mode       <= STPCR_M32;
    end else begin
      bridge_enable   <= bridge_en_nxt;
      dir_ccw         <= dir_ccw_nxt;
      step_pulse      <= step_pulse_nxt;
      coil_current_ma <= cur_nxt;
      slope_v_per_us  <= slope_nxt;
      step_mode       <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched fault flags and status snapshot
  logic [3:0] xlat_r, ylat_r, xlat_nxt, ylat_nxt;
  logic       tsd_r, tsd_nxt, clr_x, clr_y;
  logic [7:0] st_r [4];
  logic [7:0] st_nxt [4];
  logic [7:0] rd_nxt;

  assign clr_x = rd_load & (rd_addr == `STPCR_OFF_X_OVC);
  assign clr_y = rd_load & (rd_addr == `STPCR_OFF_Y_THERM);

  always_comb begin
    // A new event in the clearing cycle keeps the flag set
    xlat_nxt = (xlat_r & {4{~clr_x}}) | cond_s.x_ovc;
    ylat_nxt = (ylat_r & {4{~clr_y}}) | cond_s.y_ovc;
    tsd_nxt  = (tsd_r & ~clr_y) | cond_s.thermal_shutdown_flag;
    st_nxt   = st_r;
    if (cs_s) begin
      st_nxt[0] = with_par({cond_s.thermal_warning_flag, cond_s.cp_fail_flag, 1'b0,
                            cond_s.open_coil_x_flag, cond_s.open_coil_y_flag,
                            2'b00});
      st_nxt[1] = with_par({xlat_r, 3'b000});
      st_nxt[2] = with_par({ylat_r, tsd_r, 2'b00});
      st_nxt[3] = with_par(microstep_position);
    end
    case (rd_addr)
      `STPCR_OFF_CR0:      rd_nxt = cr0_r;
      `STPCR_OFF_CR1:      rd_nxt = cr1_r;
      `STPCR_OFF_CR2:      rd_nxt = cr2_r;
      `STPCR_OFF_FAULT_A:  rd_nxt = st_r[0];
      `STPCR_OFF_X_OVC:    rd_nxt = st_r[1];
      `STPCR_OFF_Y_THERM:  rd_nxt = st_r[2];
      `STPCR_OFF_POSITION: rd_nxt = st_r[3];
      default:             rd_nxt = 8'h00;
    endcase
    if (!rd_load) begin
      rd_nxt = rd_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xlat_r  <= 4'h0;
      ylat_r  <= 4'h0;
      tsd_r   <= 1'b0;
      rd_data <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        st_r[i] <= `STPCR_STAT_RST;
      end
    end else begin
      xlat_r  <= xlat_nxt;
      ylat_r  <= ylat_nxt;
      tsd_r   <= tsd_nxt;
      rd_data <= rd_nxt;
      st_r    <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_bridge_en_write: assert property (
    wr.en && wr.addr == `STPCR_OFF_CR2 |=> ##1 bridge_enable == $past(wr.data[7], 2)
  ) else $error("bridge enable does not follow motor enable write");

  a_bridge_off: assert property (
    !cr2_r[`STPCR_MOTEN_BIT] |=> !bridge_enable
  ) else $error("bridge enabled while motor enable is clear");

  a_dir_combine: assert property (
    ##1 dir_ccw == ($past(dir_s) != $past(cr1_r[`STPCR_DIRINV_BIT]))
  ) else $error("direction not the xor of pin and invert bit");

  a_step_edge_sel: assert property (
    (step_s != step_d_r) && (step_s ^ step_pol) |=> step_pulse
  ) else $error("selected step edge produced no pulse");

  a_step_edge_ign: assert property (
    (step_s == step_d_r) || !(step_s ^ step_pol) |=> !step_pulse
  ) else $error("step pulse on wrong edge or no edge");

  a_current_ends: assert property (
    peak_current_code == 5'h00 |=> coil_current_ma == 10'h00F
  ) else $error("lowest current code not 15 mA");

  a_current_top: assert property (
    peak_current_code == 5'h1F |=> coil_current_ma == 10'h320
  ) else $error("highest current code not 800 mA");

  a_slope_slowest: assert property (
    slew_rate_code == 2'b11 |=> slope_v_per_us == 8'h19
  ) else $error("slowest slope code not 25 V/us");

  a_slope_fastest: assert property (
    slew_rate_code == 2'b00 |=> slope_v_per_us == 8'h96
  ) else $error("fastest slope code not 150 V/us");

  a_mode_full: assert property (
    step_mode_code == 3'b110 |=> step_mode == STPCR_FULL
  ) else $error("full step code not decoded");

  a_mode_half: assert property (
    step_mode_code == 3'b100 |=> step_mode == STPCR_HALF_UNCOMP
  ) else $error("uncompensated half step code not decoded");

  a_fault_live: assert property (
    cs_s |=> st_r[0][6:5] == $past({cond_s.thermal_warning_flag, cond_s.cp_fail_flag})
  ) else $error("fault register does not follow live conditions");

  a_fault_unused: assert property (
    st_r[0][4] == 1'b0 && st_r[0][1:0] == 2'b00
  ) else $error("unused fault register bits not zero");

  a_x_snap: assert property (
    cs_s |=> st_r[1][6:3] == $past(xlat_r)
  ) else $error("x over-current snapshot does not show latched flags");

  a_y_snap: assert property (
    cs_s |=> st_r[2][6:2] == $past({ylat_r, tsd_r})
  ) else $error("y register snapshot does not show latched flags");

  a_parity_all: assert property (
    (^st_r[0]) == `STPCR_PAR_ODD && (^st_r[1]) == `STPCR_PAR_ODD &&
    (^st_r[2]) == `STPCR_PAR_ODD && (^st_r[3]) == `STPCR_PAR_ODD
  ) else $error("status parity bit wrong");

  a_snap_frozen: assert property (
    !cs_s |=> $stable(st_r[1]) && $stable(st_r[3])
  ) else $error("status changed while chip select low");

  a_xlat_hold: assert property (
    xlat_r[3] && !clr_x |=> xlat_r[3]
  ) else $error("x over-current flag dropped without read");

  a_tsd_hold: assert property (
    tsd_r && !clr_y |=> tsd_r
  ) else $error("shutdown flag dropped without read");

  a_set_wins: assert property (
    clr_y && cond_s.thermal_shutdown_flag |=> tsd_r
  ) else $error("shutdown event lost in clearing cycle");

  a_x_read_clear: assert property (
    clr_x && cond_s.x_ovc == 4'h0 |=> xlat_r == 4'h0
  ) else $error("x over-current flags not cleared by read");

  a_live_pos: assert property (
    cs_s |=> st_r[3][6:0] == $past(microstep_position)
  ) else $error("position snapshot not live");

  c_step_fall: cover property (step_pol && step_pulse);
  c_x_read_clear: cover property (xlat_r != 4'h0 && clr_x ##1 xlat_r == 4'h0);
  c_bridge_on: cover property (!bridge_enable ##1 bridge_enable);
  c_tsd_seen: cover property (st_r[2][`STPCR_TSD_BIT]);

endmodule

// File: include/stpcr_consts.svh
`ifndef STPCR_CONSTS_SVH
`define STPCR_CONSTS_SVH

// Register offsets
`define STPCR_OFF_CR0        3'h1
`define STPCR_OFF_CR1        3'h2
`define STPCR_OFF_CR2        3'h3
`define STPCR_OFF_FAULT_A    3'h4
`define STPCR_OFF_X_OVC      3'h5
`define STPCR_OFF_Y_THERM    3'h6
`define STPCR_OFF_POSITION   3'h7

// Reset values
`define STPCR_CTRL_RST       8'h00
`define STPCR_STAT_RST       8'h00

// Control field positions
`define STPCR_MODE_MSB       7
`define STPCR_MODE_LSB       5
`define STPCR_CUR_MSB        4
`define STPCR_CUR_LSB        0
`define STPCR_DIRINV_BIT     7
`define STPCR_STEPPOL_BIT    6
`define STPCR_SLEW_MSB       1
`define STPCR_SLEW_LSB       0
`define STPCR_MOTEN_BIT      7

// Status field positions
`define STPCR_PAR_BIT        7
`define STPCR_TW_BIT         6
`define STPCR_CPF_BIT        5
`define STPCR_OPEN_COIL_X_FLAG_BIT      3
`define STPCR_OPEN_COIL_Y_FLAG_BIT      2
`define STPCR_OVC_MSB        6
`define STPCR_OVC_LSB        3
`define STPCR_TSD_BIT        2

// Parity sense: 1'b0 gives even parity over all eight bits
`define STPCR_PAR_ODD        1'b0

`endif

// File: include/stpcr_pkg.sv
package stpcr_pkg;

  typedef enum logic [2:0] {
    STPCR_M32,
    STPCR_M16,
    STPCR_M8,
    STPCR_M4,
    STPCR_HALF_UNCOMP,
    STPCR_HALF_COMP,
    STPCR_FULL,
    STPCR_MODE_RSVD
  } stpcr_mode_t;

  // Raw fault and monitor conditions from the analog side
  typedef struct packed {
    logic       thermal_warning_flag;
    logic       cp_fail_flag;
    logic       open_coil_x_flag;
    logic       open_coil_y_flag;
    logic [3:0] x_ovc;     // pos top, pos bottom, neg top, neg bottom
    logic [3:0] y_ovc;
    logic       thermal_shutdown_flag;
  } stpcr_cond_t;

  typedef struct packed {
    logic       en;
    logic [2:0] addr;
    logic [7:0] data;
  } stpcr_wr_t;

endpackage

// File: tb/stpcr_framer_model.sv
`timescale 1ns/100ps
// Serial framer stand-in: one byte per frame, chip select low for the whole frame
module stpcr_framer_model (
  input  wire logic            clk_sys,
  input  wire logic [7:0]      rd_data,
  output stpcr_pkg::stpcr_wr_t wr,
  output logic                 rd_load,
  output logic [2:0]           rd_addr,
  output logic                 serial_chip_select
);
  import stpcr_pkg::*;
  initial begin
    wr = '0;
    rd_load = 1'b0;
    rd_addr = 3'h0;
    serial_chip_select = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Buffer load sits at the eighth bit, so status frozen at frame start is returned
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_sys);
    serial_chip_select <= 1'b0;
    repeat (8) @(negedge clk_sys);
    if (w) begin
      wr <= '{en: 1'b1, addr: a, data: d};
    end else begin
      rd_load <= 1'b1;
      rd_addr <= a;
    end
    @(negedge clk_sys);
    wr <= '0;
    rd_load <= 1'b0;
    q = rd_data;
    serial_chip_select <= 1'b1;
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import stpcr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  stpcr_wr_t   wr;
  logic        rd_load;
  logic [2:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        serial_chip_select;
  logic        direction_pin = 1'b0;
  logic        step_input_pin = 1'b0;
  stpcr_cond_t cond = '0;
  logic [6:0]  microstep_position = 7'h00;
  logic        bridge_enable;
  logic        dir_ccw;
  logic        step_pulse;
  logic [9:0]  coil_current_ma;
  logic [7:0]  slope_v_per_us;
  stpcr_mode_t step_mode;
  logic [31:0] seed = 32'hc7b4_e7f0;
  logic [7:0]  q;
  int          err_total = 0;
  int          compares = 0;
  int          n;
  int          cur_tab [32] = '{15, 30, 45, 50, 55, 61, 67, 74, 82, 91, 100, 110, 122, 135, 149,
    164, 181, 200, 221, 244, 269, 297, 328, 362, 400, 441, 487, 538, 594, 656, 724, 800};
  int          slope_tab [4] = '{150, 100, 50, 25};

  always #2 clk_sys = ~clk_sys;

  stpcr_regs stpcr_regs_inst (.clk_sys(clk_sys), .rst(rst), .wr(wr), .rd_load(rd_load),
    .rd_addr(rd_addr), .rd_data(rd_data), .serial_chip_select(serial_chip_select),
    .direction_pin(direction_pin), .step_input_pin(step_input_pin), .cond(cond),
    .microstep_position(microstep_position), .bridge_enable(bridge_enable),
    .dir_ccw(dir_ccw), .step_pulse(step_pulse), .coil_current_ma(coil_current_ma),
    .slope_v_per_us(slope_v_per_us), .step_mode(step_mode));
  stpcr_framer_model stpcr_framer_model_inst (.clk_sys(clk_sys), .rd_data(rd_data), .wr(wr),
    .rd_load(rd_load), .rd_addr(rd_addr), .serial_chip_select(serial_chip_select));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] with_par(input logic [6:0] b);
    return {^b, b};
  endfunction
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    stpcr_framer_model_inst.xfer(1'b0, a, 8'h00, q);
    compares++;
    if (q !== exp) begin
      err_total++;
      $display("[ERR] %0t reg %0d read %h want %h", $time, a, q, exp);
    end
  endtask
  task automatic chk_out(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t output %0d want %0d", $time, got, exp);
    end
  endtask
  // Settle time covers register plus output flop and the pin synchronisers
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    stpcr_framer_model_inst.xfer(1'b1, a, d, q);
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic pulses(output int k);
    k = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (step_pulse === 1'b1) k++;
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int a = 4; a < 8; a++) chk_reg(3'(a), 8'h00);
    for (int c = 0; c < 32; c++) begin
      put(3'h1, {3'(c), 5'(c)});
      chk_out(coil_current_ma, 10'(cur_tab[c]));
      chk_out({7'h0, step_mode}, {7'h0, 3'(c)});
    end
    for (int i = 0; i < 4; i++) begin
      direction_pin = 1'(i >> 1);
      put(3'h2, {1'(i), 1'(i >> 1), 4'h0, 2'(i)});
      chk_out(10'(slope_v_per_us), 10'(slope_tab[i]));
      chk_out(10'(dir_ccw), 10'(direction_pin ^ 1'(i)));
      repeat (2) begin
        @(negedge clk_sys);
        step_input_pin = ~step_input_pin;
        pulses(n);
        chk_out(10'(n), 10'(step_input_pin ^ 1'(i >> 1)));
      end
    end
    put(3'h3, 8'h80);
    chk_out(10'(bridge_enable), 10'h001);
    put(3'h3, 8'h00);
    chk_out(10'(bridge_enable), 10'h000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      {cond.thermal_warning_flag, cond.cp_fail_flag} = seed[3:2];
      {cond.open_coil_x_flag, cond.open_coil_y_flag} = seed[1:0];
      microstep_position = seed[14:8];
      repeat (6) @(negedge clk_sys);
      chk_reg(3'h4, with_par({seed[3:2], 1'b0, seed[1:0], 2'b00}));
      chk_reg(3'h7, with_par(seed[14:8]));
    end
    cond = '0;
    repeat (6) @(negedge clk_sys);
    chk_reg(3'h4, 8'h00);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      if (k == 0) cond.x_ovc = seed[3:0] | 4'h1;
      else {cond.y_ovc, cond.thermal_shutdown_flag} = {seed[3:0] | 4'h1, seed[4]};
      repeat (6) @(negedge clk_sys);
      cond = '0;
      repeat (6) @(negedge clk_sys);
      chk_reg(3'(5 + k), with_par({seed[3:0] | 4'h1, seed[4] & 1'(k), 2'b00}));
      repeat (6) @(negedge clk_sys);
      chk_reg(3'(5 + k), 8'h00);
    end
    // Shutdown still present at the read: the flag must survive the clear
    cond.thermal_shutdown_flag = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk_reg(3'h6, with_par(7'h04));
    cond = '0;
    repeat (6) @(negedge clk_sys);
    chk_reg(3'h6, with_par(7'h04));
    repeat (6) @(negedge clk_sys);
    chk_reg(3'h6, 8'h00);
    // Reset in mid-run must drop latched flags and control state
    cond.x_ovc = 4'h9;
    put(3'h3, 8'h80);
    cond = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_out(10'(bridge_enable), 10'h000);
    chk_reg(3'h5, 8'h00);
    // Position moves mid-frame; the frozen snapshot must still be returned
    fork
      chk_reg(3'h7, with_par(microstep_position));
      begin
        repeat (4) @(negedge clk_sys);
        microstep_position = ~microstep_position;
      end
    join
    repeat (6) @(negedge clk_sys);
    chk_reg(3'h7, with_par(microstep_position));
    tally_and_finish();
  end
endmodule
